// ===== design/pmw_pkg.sv
// Contract
// - select code 111 runs slow clock
// - codes 000-110 run fast clock divided
// - fast oscillator restart shows unstable flag
// - halt with both keeps 0 enters sleep
// - fast 0 slow 1 enters low-clock idle
// - both keeps 1 enters both-clocks idle
// - fast 1 slow 0 enters fast-clock idle
// - power-down halts core, keeps state
// - entry sets powerdown, clears timeout flag
// - entry clears watchdog count
// - wake on reset, porta, interrupt, watchdog
// - pin wake resets system, watchdog wake resets watchdog
// - powerdown flag cleared by power-up or clear
// - watchdog wake sets timeout, resets pc, sp
// - per-pin porta wake enable except pin 2, which never wakes, resume after halt
// - disabled or stack full resumes after halt
// - enabled with stack room takes interrupt
// - interrupt pending before halt cannot wake
package pmw_pkg;
  localparam int PORTA_W = 8;
  localparam int IRQ_W = 8;
  localparam int PIN_TWO = 2;
  localparam logic [2:0] CKS_SLOW = 3'h7;
  localparam logic [2:0] CKS_FAST_MAX = 3'h6;
  localparam logic [7:0] SCC_RESET = 8'h00;
  localparam logic [7:0] FOSC_CTRL_RESET = 8'h01;
  localparam int CKS_LSB = 5;
  localparam int FAST_OSC_KEEP_ENABLE_BIT = 1;
  localparam int SLOW_OSC_KEEP_ENABLE_BIT = 0;
  localparam int FOSC_EN_BIT = 0;
  localparam int FOSC_FLAG_BIT = 1;
  // register offsets, one byte each
  localparam logic [3:0] ADDR_SCC = 4'h0;
  localparam logic [3:0] ADDR_FOSC = 4'h1;
  localparam logic [3:0] ADDR_PAWAKE = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_INT_STAT = 4'h4;
  localparam logic [3:0] ADDR_INT_EN = 4'h5;
  localparam logic [3:0] ADDR_INT_CLR = 4'h6;
  localparam logic [3:0] ADDR_MODE = 4'h7;
  // event bits
  localparam int EV_ENTRY = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_WDT = 2;
  localparam int EV_STABLE = 3;
  localparam int EV_W = 4;
  // oscillator settle time, ns, and cycles at 200 MHz
  localparam int FOSC_SETTLE_NS = 1000;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int FOSC_SETTLE_CYC = (FOSC_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  typedef enum logic [2:0] {
    PMW_RUN = 3'b000,
    PMW_SLEEP = 3'b001,
    PMW_LOW_CLOCK_ONLY_MODE = 3'b011,
    PMW_BOTH_CLOCKS_ON_MODE = 3'b010,
    PMW_FAST_CLOCK_ONLY_MODE = 3'b110,
    PMW_WAKE = 3'b100
  } pmw_state_t;
endpackage

// ===== design/pmw_power_mode_wakeup_control.sv
`timescale 1ns/1ps
module pmw_power_mode_wakeup_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  input wire logic power_up,
  input wire logic reset_pin_n,
  input wire logic [pmw_pkg::PORTA_W-1:0] porta_in,
  input wire logic [pmw_pkg::IRQ_W-1:0] irq_flag,
  input wire logic [pmw_pkg::IRQ_W-1:0] irq_enable,
  input wire logic stack_full,
  input wire logic wdt_overflow,
  input wire logic fosc_ready,
  output logic cpu_clk_en,
  output logic fast_clk_on,
  output logic slow_clk_on,
  output logic slow_mode,
  output logic [2:0] clock_div_sel,
  output logic fast_osc_en,
  output logic powerdown_flag,
  output logic watchdog_timeout_flag,
  output logic wdt_clear,
  output logic system_reset,
  output logic watchdog_reset,
  output logic take_interrupt,
  output logic resume_after_halt,
  output logic irq_out
);
  import pmw_pkg::*;

  logic [2:0] clock_select_field;
  logic fast_osc_keep_enable;
  logic slow_osc_keep_enable;
  logic fast_osc_control_reg;
  logic fast_osc_stable_flag;
  logic [PORTA_W-1:0] porta_wake_enable;
  logic [PORTA_W-1:0] pa_s1, pa_s2, pa_prev;
  logic rp_s1, rp_s2;
  logic fr_s1, fr_s2;
  logic [IRQ_W-1:0] irq_mask_at_halt;
  logic [EV_W-1:0] int_stat, int_en;
  logic [$clog2(FOSC_SETTLE_CYC+1)-1:0] settle_cnt;
  pmw_state_t state, next_state;
  logic entering;
  logic pa_wake, irq_wake, pin_wake, wdt_wake, any_wake, need_settle;
  logic [PORTA_W-1:0] pa_fall;

  function automatic logic is_reg(input logic [3:0] a, input logic [3:0] off);
    is_reg = (a == off);
  endfunction

  // input synchronisers for pins and oscillator ready
  always_ff @(posedge clk) begin
    if (rst) begin
      pa_s1 <= '1;
      pa_s2 <= '1;
      pa_prev <= '1;
      rp_s1 <= 1'b1;
      rp_s2 <= 1'b1;
      fr_s1 <= 1'b0;
      fr_s2 <= 1'b0;
    end else begin
      pa_s1 <= porta_in;
      pa_s2 <= pa_s1;
      pa_prev <= pa_s2;
      rp_s1 <= reset_pin_n;
      rp_s2 <= rp_s1;
      fr_s1 <= fosc_ready;
      fr_s2 <= fr_s1;
    end
  end

  // wake source decode
  always_comb begin
    pa_fall = pa_prev & ~pa_s2 & porta_wake_enable;
    pa_fall[PIN_TWO] = 1'b0;
    pa_wake = |pa_fall;
    irq_wake = |(irq_flag & ~irq_mask_at_halt);
    pin_wake = ~rp_s2;
    wdt_wake = wdt_overflow;
    any_wake = pa_wake | irq_wake | pin_wake | wdt_wake;
    entering = (state == PMW_RUN) && halt_exec && cpu_clk_en;
  end

  // software registers
  always_ff @(posedge clk) begin
    if (rst) begin
      clock_select_field <= SCC_RESET[7:CKS_LSB];
      fast_osc_keep_enable <= SCC_RESET[FAST_OSC_KEEP_ENABLE_BIT];
      slow_osc_keep_enable <= SCC_RESET[SLOW_OSC_KEEP_ENABLE_BIT];
      fast_osc_control_reg <= FOSC_CTRL_RESET[FOSC_EN_BIT];
      porta_wake_enable <= '0;
      int_en <= '0;
    end else if (reg_wr) begin
      if (is_reg(reg_addr, ADDR_SCC)) begin
        clock_select_field <= reg_wdata[7:CKS_LSB];
        fast_osc_keep_enable <= reg_wdata[FAST_OSC_KEEP_ENABLE_BIT];
        slow_osc_keep_enable <= reg_wdata[SLOW_OSC_KEEP_ENABLE_BIT];
      end
      if (is_reg(reg_addr, ADDR_FOSC)) fast_osc_control_reg <= reg_wdata[FOSC_EN_BIT];
      if (is_reg(reg_addr, ADDR_PAWAKE)) porta_wake_enable <= reg_wdata;
      if (is_reg(reg_addr, ADDR_INT_EN)) int_en <= reg_wdata[EV_W-1:0];
    end
  end

  // interrupt snapshot at halt
  always_ff @(posedge clk) begin
    if (rst) irq_mask_at_halt <= '0;
    else if (entering) irq_mask_at_halt <= irq_flag;
    else if (state == PMW_RUN) irq_mask_at_halt <= '0;
  end

  // power mode state machine
  always_comb begin
    next_state = state;
    case (state)
      PMW_RUN: begin
        if (entering) begin
          case ({fast_osc_keep_enable, slow_osc_keep_enable})
            2'b00: next_state = PMW_SLEEP;
            2'b01: next_state = PMW_LOW_CLOCK_ONLY_MODE;
            2'b11: next_state = PMW_BOTH_CLOCKS_ON_MODE;
            default: next_state = PMW_FAST_CLOCK_ONLY_MODE;
          endcase
        end
      end
      PMW_SLEEP, PMW_LOW_CLOCK_ONLY_MODE, PMW_BOTH_CLOCKS_ON_MODE, PMW_FAST_CLOCK_ONLY_MODE: begin
        if (any_wake) next_state = need_settle ? PMW_WAKE : PMW_RUN;
      end
      PMW_WAKE: if (fast_osc_stable_flag) next_state = PMW_RUN;
      default: next_state = PMW_RUN;
    endcase
  end

  // stopped fast oscillator must restart on wake when it clocks the core
  always_comb begin
    need_settle = (clock_select_field != CKS_SLOW) && !fast_clk_on;
    if (state == PMW_SLEEP) need_settle = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) state <= PMW_RUN;
    else state <= next_state;
  end

  // clock outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_clk_en <= 1'b1;
      fast_clk_on <= 1'b1;
      slow_clk_on <= 1'b1;
      slow_mode <= 1'b0;
      clock_div_sel <= '0;
      fast_osc_en <= 1'b1;
    end else begin
      cpu_clk_en <= (next_state == PMW_RUN);
      slow_mode <= (clock_select_field == CKS_SLOW);
      clock_div_sel <= (clock_select_field <= CKS_FAST_MAX) ? clock_select_field
                                                              : clock_div_sel;
      case (next_state)
        PMW_SLEEP: begin
          fast_clk_on <= 1'b0;
          slow_clk_on <= 1'b0;
        end
        PMW_LOW_CLOCK_ONLY_MODE: begin
          fast_clk_on <= 1'b0;
          slow_clk_on <= 1'b1;
        end
        PMW_BOTH_CLOCKS_ON_MODE: begin
          fast_clk_on <= 1'b1;
          slow_clk_on <= 1'b1;
        end
        PMW_FAST_CLOCK_ONLY_MODE: begin
          fast_clk_on <= 1'b1;
          slow_clk_on <= 1'b0;
        end
        default: begin
          fast_clk_on <= fast_osc_control_reg || (clock_select_field != CKS_SLOW);
          slow_clk_on <= 1'b1;
        end
      endcase
      fast_osc_en <= (next_state == PMW_RUN || next_state == PMW_WAKE)
                     ? (fast_osc_control_reg || clock_select_field != CKS_SLOW)
                     : (next_state == PMW_BOTH_CLOCKS_ON_MODE || next_state == PMW_FAST_CLOCK_ONLY_MODE);
    end
  end

  // oscillator stable flag with settle count
  always_ff @(posedge clk) begin
    if (rst) begin
      fast_osc_stable_flag <= 1'b1;
      settle_cnt <= '0;
    end else if (!fast_osc_en) begin
      fast_osc_stable_flag <= 1'b0;
      settle_cnt <= '0;
    end else if (!fast_osc_stable_flag) begin
      if (fr_s2 && settle_cnt == ($bits(settle_cnt))'(FOSC_SETTLE_CYC - 1))
        fast_osc_stable_flag <= 1'b1;
      else if (fr_s2)
        settle_cnt <= settle_cnt + 1'b1;
    end
  end

  // status flags
  always_ff @(posedge clk) begin
    if (rst) begin
      powerdown_flag <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
    end else begin
      // powerdown clear must not swallow a watchdog timeout in the same cycle
      if (power_up || clr_wdt_exec) powerdown_flag <= 1'b0;
      else if (entering) powerdown_flag <= 1'b1;
      if (entering && !(power_up || clr_wdt_exec)) watchdog_timeout_flag <= 1'b0;
      else if (wdt_overflow) watchdog_timeout_flag <= 1'b1;
    end
  end

  // wake actions, one-cycle pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      wdt_clear <= 1'b0;
      system_reset <= 1'b0;
      watchdog_reset <= 1'b0;
      take_interrupt <= 1'b0;
      resume_after_halt <= 1'b0;
    end else begin
      wdt_clear <= entering || clr_wdt_exec;
      system_reset <= 1'b0;
      watchdog_reset <= 1'b0;
      take_interrupt <= 1'b0;
      resume_after_halt <= 1'b0;
      if (state != PMW_RUN && state != PMW_WAKE && any_wake) begin
        if (pin_wake) system_reset <= 1'b1;
        else if (wdt_wake) watchdog_reset <= 1'b1;
        else if (irq_wake && |(irq_flag & ~irq_mask_at_halt & irq_enable) && !stack_full)
          take_interrupt <= 1'b1;
        else resume_after_halt <= 1'b1;
      end
    end
  end

  // sticky event status, set wins over clear
  always_ff @(posedge clk) begin
    logic [EV_W-1:0] ev;
    ev = '0;
    ev[EV_ENTRY] = entering;
    ev[EV_WAKE] = (state != PMW_RUN) && (state != PMW_WAKE) && any_wake;
    ev[EV_WDT] = wdt_overflow;
    ev[EV_STABLE] = (state == PMW_WAKE) && fast_osc_stable_flag;
    if (rst) int_stat <= '0;
    else if (reg_wr && is_reg(reg_addr, ADDR_INT_CLR))
      int_stat <= (int_stat & ~reg_wdata[EV_W-1:0]) | ev;
    else int_stat <= int_stat | ev;
  end

  always_ff @(posedge clk) begin
    if (rst) irq_out <= 1'b0;
    else irq_out <= |(int_stat & int_en);
  end

  // read port, data in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) reg_rdata <= '0;
    else if (reg_rd) begin
      case (reg_addr)
        ADDR_SCC: reg_rdata <= {clock_select_field, 3'h0, fast_osc_keep_enable,
                                slow_osc_keep_enable};
        ADDR_FOSC: reg_rdata <= {6'h00, fast_osc_stable_flag, fast_osc_control_reg};
        ADDR_PAWAKE: reg_rdata <= porta_wake_enable;
        ADDR_STATUS: reg_rdata <= {6'h00, watchdog_timeout_flag, powerdown_flag};
        ADDR_INT_STAT: reg_rdata <= {4'h0, int_stat};
        ADDR_INT_EN: reg_rdata <= {4'h0, int_en};
        ADDR_MODE: reg_rdata <= {5'h00, state};
        default: reg_rdata <= 8'h00;
      endcase
    end else reg_rdata <= 8'h00;
  end
endmodule // pmw_power_mode_wakeup_control

// ===== verif/pmw_power_mode_wakeup_control_checker.sv
`timescale 1ns/1ps
module pmw_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  input wire logic power_up,
  input wire logic wdt_overflow,
  input wire logic cpu_clk_en,
  input wire logic fast_osc_en,
  input wire logic slow_mode,
  input wire logic [2:0] clock_div_sel,
  input wire logic powerdown_flag,
  input wire logic watchdog_timeout_flag,
  input wire logic wdt_clear,
  input wire logic system_reset,
  input wire logic watchdog_reset,
  input wire logic take_interrupt,
  input wire logic resume_after_halt
);
  import pmw_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // halt entry flags, core gating and watchdog clear
  property p_entry;
    halt_exec && cpu_clk_en |=> powerdown_flag && !watchdog_timeout_flag;
  endproperty
  a_entry: assert property (p_entry) else $error("entry flags wrong");
  property p_gate;
    halt_exec && cpu_clk_en |=> !cpu_clk_en [*2];
  endproperty
  a_gate: assert property (p_gate) else $error("core not stopped");
  property p_wdclr;
    halt_exec && cpu_clk_en |=> wdt_clear ##1 !wdt_clear;
  endproperty
  a_wdclr: assert property (p_wdclr) else $error("watchdog clear pulse wrong");
  // clock select writes
  property p_slow;
    reg_wr && reg_addr == ADDR_SCC && reg_wdata[7:5] == CKS_SLOW |=> ##1 slow_mode;
  endproperty
  a_slow: assert property (p_slow) else $error("slow mode not entered");
  property p_fast;
    reg_wr && reg_addr == ADDR_SCC && reg_wdata[7:5] <= CKS_FAST_MAX && fast_osc_en
      && cpu_clk_en |=> ##1 !slow_mode && {5'h00, clock_div_sel} == ($past(reg_wdata, 2) >> 5);
  endproperty
  a_fast: assert property (p_fast) else $error("divider select wrong");
  // flag updates, status read and single wake outcome
  property p_to;
    wdt_overflow && !halt_exec |=> watchdog_timeout_flag;
  endproperty
  a_to: assert property (p_to) else $error("timeout flag not set");
  property p_pdclr;
    (clr_wdt_exec || power_up) && !halt_exec |=> !powerdown_flag;
  endproperty
  a_pdclr: assert property (p_pdclr) else $error("powerdown flag not cleared");
  property p_stat;
    reg_rd && reg_addr == ADDR_STATUS |=>
      reg_rdata == {6'h00, $past(watchdog_timeout_flag), $past(powerdown_flag)};
  endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
  property p_onewake;
    $onehot0({system_reset, watchdog_reset, take_interrupt, resume_after_halt});
  endproperty
  a_onewake: assert property (p_onewake) else $error("two wake outcomes");
endmodule // pmw_checker

// ===== verif/pmw_osc_model.sv
`timescale 1ns/1ps
module pmw_osc_model #(
  parameter int SETTLE = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic fast_osc_en,
  output logic fosc_ready
);
  int cnt;
  // restart reads unstable until settled
  always_ff @(posedge clk) begin
    if (rst || !fast_osc_en) begin
      cnt <= 0;
      fosc_ready <= 1'b0;
    end else if (cnt == SETTLE) begin
      fosc_ready <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // pmw_osc_model

// ===== verif/test_power_mode_wakeup_control.sv
`timescale 1ns/1ps
module test_power_mode_wakeup_control;
  import pmw_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] pls = 4'h0;
  logic reset_pin_n = 1'b1;
  logic [7:0] porta_in = 8'hff;
  logic [7:0] irq_flag = 8'h00;
  logic [7:0] irq_enable = 8'h00;
  logic stack_full = 1'b0;
  logic [7:0] reg_rdata, d;
  logic [2:0] clock_div_sel;
  logic fosc_ready, cpu_clk_en, fast_clk_on, slow_clk_on, slow_mode, fast_osc_en;
  logic powerdown_flag, watchdog_timeout_flag, wdt_clear, system_reset, watchdog_reset;
  logic take_interrupt, resume_after_halt, irq_out;
  logic [3:0] seen = 4'h0;
  logic exp_to = 1'b0;
  logic exp_pdf = 1'b0;
  logic [7:0] seed = 8'h1e;
  int fail_count = 0;
  int checks_done = 0;
  int p;
  wire halt_exec = pls[0];
  wire clr_wdt_exec = pls[1];
  wire power_up = pls[2];
  wire wdt_overflow = pls[3];
  wire [4:0] st = {cpu_clk_en, seen};
  always #2.5 clk = ~clk;
  pmw_power_mode_wakeup_control dut_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .halt_exec, .clr_wdt_exec, .power_up, .reset_pin_n, .porta_in, .irq_flag,
    .irq_enable, .stack_full, .wdt_overflow, .fosc_ready, .cpu_clk_en, .fast_clk_on,
    .slow_clk_on, .slow_mode, .clock_div_sel, .fast_osc_en, .powerdown_flag,
    .watchdog_timeout_flag, .wdt_clear, .system_reset, .watchdog_reset, .take_interrupt,
    .resume_after_halt, .irq_out);
  pmw_osc_model #(.SETTLE(16)) osc_u (.clk, .rst, .fast_osc_en, .fosc_ready);
  // collect wake pulses between edges
  always @(negedge clk) seen = seen | {resume_after_halt, take_interrupt, watchdog_reset,
    system_reset};
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic flag_chk;
    chk({6'h00, watchdog_timeout_flag, powerdown_flag}, {6'h00, exp_to, exp_pdf});
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic strobe(int i);
    @(posedge clk) pls[i] <= 1'b1;
    @(posedge clk) pls[i] <= 1'b0;
  endtask
  task automatic halt;
    strobe(0);
    exp_pdf = 1'b1;
    exp_to = 1'b0;
    #1 flag_chk();
  endtask
  task automatic wait_hi(int b, int lim);
    int n;
    n = 0;
    while (st[b] !== 1'b1) begin
      @(posedge clk);
      #1 n++;
      if (n > lim) begin
        chk(8'h00, 8'h01);
        tally_and_finish();
      end
    end
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_SCC, d);
    chk(d, SCC_RESET);
    rd(4'h9, d);
    chk(d, 8'h00);
    wr(ADDR_SCC, {CKS_SLOW, 5'h00});
    @(posedge clk);
    #1 chk({7'h00, slow_mode}, 8'h01);
    for (int c = 0; c < 7; c++) begin
      wr(ADDR_SCC, {c[2:0], 5'h00});
      @(posedge clk);
      #1 chk({4'h0, slow_mode, clock_div_sel}, {5'h00, c[2:0]});
    end
    wr(ADDR_PAWAKE, 8'hff);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_SCC, {6'h00, k[1:0]});
      halt();
      chk({6'h00, fast_clk_on, slow_clk_on}, {6'h00, k[1:0]});
      chk({7'h00, cpu_clk_en}, 8'h00);
      seen = 4'h0;
      @(posedge clk) porta_in <= 8'hfb;
      repeat (8) @(posedge clk);
      chk({4'h0, seen}, 8'h00);
      p = seed % 8;
      if (p == PIN_TWO) p = 3;
      seed = lfsr(seed);
      @(posedge clk) porta_in <= 8'hfb & ~(8'h01 << p);
      wait_hi(3, 20);
      chk({4'h0, seen}, 8'h08);
      if (k == 0) begin
        rd(ADDR_FOSC, d);
        chk(d & 8'h02, 8'h00);
      end
      wait_hi(4, 600);
      @(posedge clk) porta_in <= 8'hff;
      repeat (4) @(posedge clk);
    end
    seen = 4'h0;
    halt();
    strobe(3);
    wait_hi(1, 20);
    exp_to = 1'b1;
    chk({4'h0, seen}, 8'h02);
    #1 flag_chk();
    wait_hi(4, 600);
    strobe(1);
    exp_pdf = 1'b0;
    #1 flag_chk();
    wr(ADDR_INT_EN, 8'h01);
    @(posedge clk) irq_enable <= 8'h03;
    for (int s = 0; s < 2; s++) begin
      seen = 4'h0;
      @(posedge clk) stack_full <= s[0];
      repeat (2) @(posedge clk);
      halt();
      @(posedge clk) irq_flag <= 8'h01;
      wait_hi(s ? 3 : 2, 20);
      chk({4'h0, seen}, s ? 8'h08 : 8'h04);
      @(posedge clk) irq_flag <= 8'h00;
      wait_hi(4, 600);
    end
    chk({7'h00, irq_out}, 8'h01);
    wr(ADDR_INT_EN, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, irq_out}, 8'h00);
    wr(ADDR_INT_CLR, 8'h0f);
    rd(ADDR_INT_STAT, d);
    chk(d, 8'h00);
    seen = 4'h0;
    @(posedge clk) irq_flag <= 8'h02;
    repeat (2) @(posedge clk);
    halt();
    repeat (8) @(posedge clk);
    chk({4'h0, seen}, 8'h00);
    @(posedge clk) reset_pin_n <= 1'b0;
    wait_hi(0, 20);
    chk({4'h0, seen}, 8'h01);
    @(posedge clk) reset_pin_n <= 1'b1;
    irq_flag <= 8'h00;
    wait_hi(4, 600);
    strobe(2);
    #1 chk({7'h00, powerdown_flag}, 8'h00);
    tally_and_finish();
  end
endmodule // test_power_mode_wakeup_control
bind pmw_power_mode_wakeup_control pmw_checker chk_u (.clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .halt_exec, .clr_wdt_exec, .power_up, .wdt_overflow,
  .cpu_clk_en, .fast_osc_en, .slow_mode, .clock_div_sel, .powerdown_flag,
  .watchdog_timeout_flag, .wdt_clear, .system_reset, .watchdog_reset, .take_interrupt,
  .resume_after_halt);
